//--- inc/pfs_params.svh
// constants of the power fault status register bank
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PFS_CMD_CLEAR_FAULTS 8'h03
`define PFS_CMD_STATUS_BYTE  8'h78
`define PFS_CMD_FLAG_SUMMARY 8'h79
`define PFS_CMD_OUT_VOLTAGE  8'h7A
`define PFS_CMD_INPUT_SUPPLY 8'h7C
`define PFS_CMD_THERMAL      8'h7D
`define PFS_CMD_LINK_ERROR   8'h7E
`define PFS_CMD_VENDOR_FAULT 8'h80

// ----------------------------------------------------------------
// summary word bit positions
// ----------------------------------------------------------------
`define PFS_SW_OUT_VOLTAGE   15
`define PFS_SW_INPUT         13
`define PFS_SW_VENDOR        12
`define PFS_SW_PGOOD_LOST    11
`define PFS_SW_SWITCH_OFF    6
`define PFS_SW_SUPPLY_LOW    3
`define PFS_SW_THERMAL       2
`define PFS_SW_COMM_ERROR    1
`define PFS_SW_OTHER         0

// ----------------------------------------------------------------
// power-up values of the stored flags and the read data
// ----------------------------------------------------------------
`define PFS_RST_STARTUP      1'b1
`define PFS_RST_PGOOD_LOST   1'b1
`define PFS_RST_DEFAULTS     1'b1
`define PFS_RST_CLEAR        1'b0
`define PFS_RST_WORD         16'h0000

`endif

//--- inc/pfs_pkg.sv
// types of the power fault status register bank
package pfs_pkg;

	// conditions from the protection and monitoring logic, levels
	typedef struct packed {
		logic out_low_warning;
		logic supply_high_fault;
		logic supply_high_warning;
		logic supply_low_warning;
		logic supply_low_fault;
		logic input_overcurrent_fault;
		logic input_overcurrent_warning;
		logic input_overpower_warning;
		logic thermal_fault;
		logic thermal_warning;
		logic breaker_fault;
		logic switch_shorted;
		logic power_good;
		logic switch_on;
		logic above_lockout;
	} pfs_cond_t;

	// communication error events from the protocol engine, pulses
	typedef struct packed {
		logic bad_command;
		logic bad_data;
		logic pec_mismatch;
		logic misc_error;
	} pfs_comm_t;

	// stored sticky flags
	typedef struct packed {
		logic startup;
		logic pgood_lost;
		logic defaults_loaded;
		logic out_low_warning;
		logic supply_high_fault;
		logic supply_high_warning;
		logic supply_low_warning;
		logic supply_low_fault;
		logic input_overcurrent_fault;
		logic input_overcurrent_warning;
		logic input_overpower_warning;
		logic thermal_fault;
		logic thermal_warning;
		logic breaker_fault;
		logic switch_shorted;
		logic bad_command;
		logic bad_data;
		logic pec_mismatch;
		logic misc_error;
	} pfs_flags_t;

endpackage

//--- logic/pfs_status_bank.sv
// sticky fault and warning status register bank with command read port
`timescale 1ns/1ps
`include "pfs_params.svh"

module pfs_status_bank
(
	input  wire logic              CLK_I,
	input  wire logic              RST_B_I,
	input  wire pfs_pkg::pfs_cond_t COND_I,
	input  wire pfs_pkg::pfs_comm_t COMM_I,
	input  wire logic              SEND_I,
	input  wire logic              RD_I,
	input  wire logic [7:0]        CMD_I,
	output logic      [15:0]       DATA_O,
	output logic                   RD_VALID_O,
	output logic                   RD_ERR_O,
	output logic                   ALERT_O
);
	import pfs_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pfs_flags_t  flags_r;
	pfs_flags_t  flags_nxt;
	logic [15:0] data_r;
	logic [15:0] data_nxt;
	logic        valid_r;
	logic        err_r;
	logic        alert_r;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire logic clr         = SEND_I && (CMD_I == `PFS_CMD_CLEAR_FAULTS);
	wire logic send_bad    = SEND_I && (CMD_I != `PFS_CMD_CLEAR_FAULTS);
	wire logic rd_word     = CMD_I == `PFS_CMD_FLAG_SUMMARY;
	wire logic rd_low      = CMD_I == `PFS_CMD_STATUS_BYTE;
	wire logic rd_out      = CMD_I == `PFS_CMD_OUT_VOLTAGE;
	wire logic rd_in       = CMD_I == `PFS_CMD_INPUT_SUPPLY;
	wire logic rd_therm    = CMD_I == `PFS_CMD_THERMAL;
	wire logic rd_link     = CMD_I == `PFS_CMD_LINK_ERROR;
	wire logic rd_vend     = CMD_I == `PFS_CMD_VENDOR_FAULT;
	wire logic rd_known    = rd_word | rd_low | rd_out | rd_in | rd_therm | rd_link | rd_vend;
	wire logic rd_bad      = RD_I && !rd_known;
	// an unknown code is itself a link error, so the host sees why it got nothing
	wire logic bad_cmd_evt = COMM_I.bad_command | rd_bad | send_bad;

	// ------------------------------------------------------------
	// sticky flag update
	// ------------------------------------------------------------
	// set wins over clear: a cause still present keeps its flag
	function automatic logic sticky(input logic flag, input logic cause, input logic clear);
		sticky = cause | (flag & ~clear);
	endfunction

	always_comb
	begin
		flags_nxt = flags_r;
		// startup flag is not touched by clear-faults, only by the supply
		flags_nxt.startup = flags_r.startup & ~COND_I.above_lockout;
		flags_nxt.pgood_lost = sticky(flags_r.pgood_lost, ~COND_I.power_good, clr);
		flags_nxt.defaults_loaded = flags_r.defaults_loaded & ~clr;
		flags_nxt.out_low_warning =
			sticky(flags_r.out_low_warning, COND_I.out_low_warning, clr);
		flags_nxt.supply_high_fault =
			sticky(flags_r.supply_high_fault, COND_I.supply_high_fault, clr);
		flags_nxt.supply_high_warning =
			sticky(flags_r.supply_high_warning, COND_I.supply_high_warning, clr);
		flags_nxt.supply_low_warning =
			sticky(flags_r.supply_low_warning, COND_I.supply_low_warning, clr);
		flags_nxt.supply_low_fault =
			sticky(flags_r.supply_low_fault, COND_I.supply_low_fault, clr);
		flags_nxt.input_overcurrent_fault =
			sticky(flags_r.input_overcurrent_fault, COND_I.input_overcurrent_fault, clr);
		flags_nxt.input_overcurrent_warning =
			sticky(flags_r.input_overcurrent_warning, COND_I.input_overcurrent_warning,
				clr);
		flags_nxt.input_overpower_warning =
			sticky(flags_r.input_overpower_warning, COND_I.input_overpower_warning, clr);
		flags_nxt.thermal_fault = sticky(flags_r.thermal_fault, COND_I.thermal_fault, clr);
		flags_nxt.thermal_warning =
			sticky(flags_r.thermal_warning, COND_I.thermal_warning, clr);
		flags_nxt.breaker_fault = sticky(flags_r.breaker_fault, COND_I.breaker_fault, clr);
		flags_nxt.switch_shorted =
			sticky(flags_r.switch_shorted, COND_I.switch_shorted, clr);
		// link flags are events: a clear alone drops them
		flags_nxt.bad_command = sticky(flags_r.bad_command, bad_cmd_evt, clr);
		flags_nxt.bad_data = sticky(flags_r.bad_data, COMM_I.bad_data, clr);
		flags_nxt.pec_mismatch = sticky(flags_r.pec_mismatch, COMM_I.pec_mismatch, clr);
		flags_nxt.misc_error = sticky(flags_r.misc_error, COMM_I.misc_error, clr);
	end

	// only unknown-code reads enter flags_nxt, through bad_command; known reads have no side effect
	always_ff @(posedge CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			flags_r                 <= '0;
			flags_r.startup         <= `PFS_RST_STARTUP;
			flags_r.pgood_lost      <= `PFS_RST_PGOOD_LOST;
			flags_r.defaults_loaded <= `PFS_RST_DEFAULTS;
		end
		else
		begin
			flags_r <= flags_nxt;
		end
	end

	// ------------------------------------------------------------
	// detail bytes
	// ------------------------------------------------------------
	wire logic [7:0] out_byte = {2'b00, flags_r.out_low_warning, 5'b00000};
	wire logic [7:0] in_byte = {flags_r.supply_high_fault,
		flags_r.supply_high_warning,
		flags_r.supply_low_warning | flags_r.startup,
		flags_r.supply_low_fault,
		1'b0,
		flags_r.input_overcurrent_fault,
		flags_r.input_overcurrent_warning,
		flags_r.input_overpower_warning};
	wire logic [7:0] therm_byte = {flags_r.thermal_fault, flags_r.thermal_warning,
		6'b000000};
	wire logic [7:0] link_byte = {flags_r.bad_command, flags_r.bad_data,
		flags_r.pec_mismatch, 3'b000, flags_r.misc_error, 1'b0};
	wire logic [7:0] vend_byte = {flags_r.breaker_fault, flags_r.switch_shorted, 1'b0,
		flags_r.defaults_loaded, 4'b0000};

	// ------------------------------------------------------------
	// summary word
	// ------------------------------------------------------------
	wire logic in_other = flags_r.supply_high_fault | flags_r.supply_high_warning
		| flags_r.supply_low_warning | flags_r.startup | flags_r.input_overcurrent_fault
		| flags_r.input_overcurrent_warning | flags_r.input_overpower_warning;
	wire logic sum_other = (|out_byte) | in_other | (|vend_byte) | flags_r.pgood_lost;
	wire logic [15:0] word = {
		|out_byte,
		1'b0,
		|in_byte,
		|vend_byte,
		flags_r.pgood_lost,
		4'b0000,
		~COND_I.switch_on,
		2'b00,
		flags_r.supply_low_fault | flags_r.startup,
		|therm_byte,
		|link_byte,
		sum_other};

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// byte registers return zero in the upper byte, so a word-wide
	// engine can still send only the low byte
	assign data_nxt = !RD_I    ? data_r
		: rd_word  ? word
		: rd_low   ? {8'h00, word[7:0]}
		: rd_out   ? {8'h00, out_byte}
		: rd_in    ? {8'h00, in_byte}
		: rd_therm ? {8'h00, therm_byte}
		: rd_link  ? {8'h00, link_byte}
		: rd_vend  ? {8'h00, vend_byte}
		: `PFS_RST_WORD;

	wire logic any_flag = (|word[15:7]) | (|word[5:0]);

	always_ff @(posedge CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			data_r  <= `PFS_RST_WORD;
			valid_r <= 1'b0;
			err_r   <= 1'b0;
			alert_r <= 1'b0;
		end
		else
		begin
			data_r  <= data_nxt;
			valid_r <= RD_I && rd_known;
			err_r   <= rd_bad;
			alert_r <= any_flag & ~clr;
		end
	end

	assign DATA_O     = data_r;
	assign RD_VALID_O = valid_r;
	assign RD_ERR_O   = err_r;
	assign ALERT_O    = alert_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);

	property p_word_read;
		RD_I && rd_word |=> RD_VALID_O && !RD_ERR_O && DATA_O == $past(word);
	endproperty
	a_word_read: assert property (p_word_read) else $error("summary word read wrong");

	property p_startup;
		COND_I.above_lockout |=> !flags_r.startup ##1 !flags_r.startup;
	endproperty
	a_startup: assert property (p_startup) else $error("startup flag not released");

	// byte registers use bits 7..4 themselves, so only word reads are held to this
	property p_unsup;
		RD_I && rd_word |=> DATA_O[14] == 1'b0 && DATA_O[10:7] == 4'h0 && DATA_O[5:4] == 2'h0;
	endproperty
	a_unsup: assert property (p_unsup) else $error("unsupported bit read as one");

	property p_switch_off;
		RD_I && rd_word && !COND_I.switch_on |=> DATA_O[`PFS_SW_SWITCH_OFF];
	endproperty
	a_switch_off: assert property (p_switch_off) else $error("switch-off bit missing");

	property p_set_wins;
		COND_I.thermal_fault && clr |=> flags_r.thermal_fault ##0 therm_byte[7];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("fault lost under clear");

	property p_clear;
		clr && !COND_I.thermal_warning |=> !flags_r.thermal_warning ##0 !ALERT_O[*1];
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not act");

	property p_link_clear;
		clr && COMM_I == '0 && !RD_I |=> link_byte == 8'h00;
	endproperty
	a_link_clear: assert property (p_link_clear) else $error("link flags kept");

	property p_pec;
		COMM_I.pec_mismatch |=> link_byte[5] until clr;
	endproperty
	a_pec: assert property (p_pec) else $error("checksum flag not held");

	property p_byte_read;
		RD_I && rd_known && !rd_word |=> DATA_O[15:8] == 8'h00 && RD_VALID_O;
	endproperty
	a_byte_read: assert property (p_byte_read) else $error("byte read not single byte");

	property p_no_side;
		RD_I && !SEND_I && COND_I.power_good && !flags_r.startup
			&& $past(COND_I.power_good) |=> flags_r.pgood_lost == $past(flags_r.pgood_lost);
	endproperty
	a_no_side: assert property (p_no_side) else $error("read changed a flag");

	c_power_up_read: cover property (RD_I && rd_word && flags_r.startup);
	c_clear_all: cover property (clr ##1 !ALERT_O);
	c_set_on_clear: cover property (clr && COND_I.thermal_fault);
	c_bad_code: cover property (rd_bad ##1 RD_ERR_O);

endmodule

//--- sim/pfs_host_model.sv
// host controller model issuing read and send-byte commands
`timescale 1ns/1ps

module pfs_host_model
(
	input  wire logic        CLK_I,
	input  wire logic [15:0] DATA_I,
	input  wire logic        RD_VALID_I,
	input  wire logic        RD_ERR_I,
	output logic             SEND_O,
	output logic             RD_O,
	output logic [7:0]       CMD_O
);
	initial
	begin
		SEND_O = 1'b0;
		RD_O   = 1'b0;
		CMD_O  = 8'h00;
	end

	// ----------------------------------------------------------------
	// command transfers
	// ----------------------------------------------------------------
	// word for 79h, byte otherwise; answer taken one cycle after
	task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v,
		output logic e);
	begin
		@(posedge CLK_I);
		RD_O  <= 1'b1;
		CMD_O <= c;
		@(posedge CLK_I);
		RD_O  <= 1'b0;
		CMD_O <= ~c; // stale code never lingers
		#1;
		d = DATA_I;
		v = RD_VALID_I;
		e = RD_ERR_I;
	end
	endtask

	// send-byte, clear-faults among them
	task automatic send(input logic [7:0] c);
	begin
		@(posedge CLK_I);
		SEND_O <= 1'b1;
		CMD_O  <= c;
		@(posedge CLK_I);
		SEND_O <= 1'b0;
		CMD_O  <= ~c;
	end
	endtask
endmodule

//--- sim/pfs_status_bank_tb.sv
// self-checking bench of the power fault status register bank
`timescale 1ns/1ps

module pfs_status_bank_tb;
	import pfs_pkg::*;

	// ----------------------------------------------------------------
	// stimulus tables
	// ----------------------------------------------------------------
	// base: power good, switch on
	localparam logic [14:0] BASE = 15'h0006;
	localparam logic [14:0] TC [17] = '{15'h4000, 15'h2000, 15'h1000, 15'h0800, 15'h0400,
		15'h0200, 15'h0100, 15'h0080, 15'h0040, 15'h0020, 15'h0010, 15'h0008, 15'h0004,
		15'h0000, 15'h0000, 15'h0000, 15'h0000};
	localparam logic [3:0] TM [17] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
	localparam logic [7:0] TR [17] = '{8'h7A, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7C,
		8'h7C, 8'h7D, 8'h7D, 8'h80, 8'h80, 8'h79, 8'h7E, 8'h7E, 8'h7E, 8'h7E};
	localparam logic [15:0] TB [17] = '{16'h0020, 16'h0080, 16'h0040, 16'h0020, 16'h0010,
		16'h0004, 16'h0002, 16'h0001, 16'h0080, 16'h0040, 16'h0080, 16'h0040, 16'h0801,
		16'h0080, 16'h0040, 16'h0020, 16'h0002};
	localparam logic [15:0] TW [17] = '{16'h8001, 16'h2001, 16'h2001, 16'h2001, 16'h2008,
		16'h2001, 16'h2001, 16'h2001, 16'h0004, 16'h0004, 16'h1001, 16'h1001, 16'h0801,
		16'h0002, 16'h0002, 16'h0002, 16'h0002};
	localparam logic [7:0] PC [7] = '{8'h79, 8'h78, 8'h7A, 8'h7C, 8'h7D, 8'h7E, 8'h80};
	localparam logic [15:0] PE [7] = '{16'h3849, 16'h0049, 16'h0000, 16'h0020, 16'h0000,
		16'h0000, 16'h0010};

	logic        clk;
	logic        rst_b;
	pfs_cond_t   cond;
	pfs_comm_t   comm;
	logic        send;
	logic        rd;
	logic [7:0]  cmd;
	logic [15:0] data;
	logic        rd_valid;
	logic        rd_err;
	logic        alert;
	int          n_fail;
	int          cmp_count;

	pfs_status_bank dut
	(
		.CLK_I      (clk),
		.RST_B_I    (rst_b),
		.COND_I     (cond),
		.COMM_I     (comm),
		.SEND_I     (send),
		.RD_I       (rd),
		.CMD_I      (cmd),
		.DATA_O     (data),
		.RD_VALID_O (rd_valid),
		.RD_ERR_O   (rd_err),
		.ALERT_O    (alert)
	);

	pfs_host_model host
	(
		.CLK_I      (clk),
		.DATA_I     (data),
		.RD_VALID_I (rd_valid),
		.RD_ERR_I   (rd_err),
		.SEND_O     (send),
		.RD_O       (rd),
		.CMD_O      (cmd)
	);

	// ----------------------------------------------------------------
	// checking tasks
	// ----------------------------------------------------------------
	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
	begin
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
	begin
		chk16(n, {15'h0000, e}, {15'h0000, g});
	end
	endtask

	task automatic rdc(input logic [7:0] c, input logic [15:0] e, input logic er);
		logic [15:0] d;
		logic        v;
		logic        x;
	begin
		host.rd(c, d, v, x);
		chk16("read data", e, d);
		chk1("read valid", ~er, v);
		chk1("read error", er, x);
	end
	endtask

	task automatic end_sim;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// whole run is a few hundred cycles
	initial
	begin
		#200000;
		n_fail++;
		end_sim();
	end

	initial
	begin
		n_fail    = 0;
		cmp_count = 0;
		rst_b     = 1'b0;
		cond      = pfs_cond_t'(15'h0004);
		comm      = '0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 7; i++)
			rdc(PC[i], PE[i], 1'b0);
		chk1("alert", 1'b1, alert);
		host.send(8'h03);
		rdc(8'h79, 16'h2049, 1'b0);
		@(posedge clk);
		cond <= pfs_cond_t'(15'h0005);
		@(posedge clk);
		cond <= pfs_cond_t'(15'h0004);
		rdc(8'h79, 16'h0040, 1'b0);
		rdc(8'h7C, 16'h0000, 1'b0);
		@(posedge clk);
		cond <= pfs_cond_t'(BASE);
		rdc(8'h79, 16'h0000, 1'b0);
		chk1("alert", 1'b0, alert);
		// one cause at a time, then cleared
		for (int i = 0; i < 17; i++)
		begin
			@(posedge clk);
			cond <= pfs_cond_t'(BASE ^ TC[i]);
			comm <= pfs_comm_t'(TM[i]);
			@(posedge clk);
			cond <= pfs_cond_t'(BASE);
			comm <= '0;
			rdc(TR[i], TB[i], 1'b0);
			rdc(8'h79, TW[i], 1'b0);
			chk1("alert", 1'b1, alert);
			host.send(8'h03);
			#1;
			chk1("alert", 1'b0, alert);
			rdc(TR[i], 16'h0000, 1'b0);
		end
		// cause still present when cleared
		@(posedge clk);
		cond <= pfs_cond_t'(BASE | 15'h0040);
		host.send(8'h03);
		rdc(8'h7D, 16'h0080, 1'b0);
		@(posedge clk);
		cond <= pfs_cond_t'(BASE);
		host.send(8'h03);
		rdc(8'h7D, 16'h0000, 1'b0);
		// unknown codes
		rdc(8'h7B, 16'h0000, 1'b1);
		rdc(8'h7E, 16'h0080, 1'b0);
		host.send(8'h03);
		host.send(8'h55);
		rdc(8'h7E, 16'h0080, 1'b0);
		host.send(8'h03);
		rdc(8'h7E, 16'h0000, 1'b0);
		// reset in mid-run brings the power-up flags back
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		chk1("alert in reset", 1'b0, alert);
		chk16("data in reset", 16'h0000, data);
		rst_b <= 1'b1;
		rdc(8'h79, 16'h3809, 1'b0);
		chk1("alert", 1'b1, alert);
		rdc(8'h80, 16'h0010, 1'b0);
		end_sim();
	end
endmodule
